// ### rtl/dmb_pkg.sv
// constants, field layouts and carrier types for the ddr mode and burst block
package dmb_pkg;

  // pin group carried through the synchroniser
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
  } dmb_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_XFER = 2'h3
  } dmb_state_t;

  // {ras_n, cas_n, we_n} command codes
  localparam logic [2:0] OP_MODE = 3'h0;
  localparam logic [2:0] OP_REF = 3'h1;
  localparam logic [2:0] OP_PRE = 3'h2;
  localparam logic [2:0] OP_ACT = 3'h3;
  localparam logic [2:0] OP_WR = 3'h4;
  localparam logic [2:0] OP_RD = 3'h5;
  localparam logic [2:0] OP_STOP = 3'h6;

  localparam logic [1:0] BA_BASE = 2'h0;
  localparam logic [1:0] BA_EXT = 2'h1;
  localparam int unsigned AP_BIT = 10;

  // mode register fields
  localparam int unsigned MR_BL_LSB = 0;
  localparam int unsigned MR_BT_BIT = 3;
  localparam int unsigned MR_CL_LSB = 4;
  localparam int unsigned MR_OP_LSB = 7;
  localparam logic [5:0] MR_OP_NORMAL = 6'h00;
  localparam logic [5:0] MR_OP_DLL = 6'h02;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] MASK_2 = 3'h1;
  localparam logic [2:0] MASK_4 = 3'h3;
  localparam logic [2:0] MASK_8 = 3'h7;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [2:0] CL_25 = 3'h6;
  // latency in link half periods (edges)
  localparam logic [2:0] LAT_CL2 = 3'h2;
  localparam logic [2:0] LAT_CL25 = 3'h3;
  localparam logic [2:0] LAT_CL3 = 3'h4;
  localparam logic [2:0] LAT_WR = 3'h2;

  // apb map
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_EMODE = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam int unsigned ST_MODE_OK = 0;
  localparam int unsigned ST_EMODE_OK = 1;
  localparam int unsigned ST_DLL_PEND = 2;
  localparam int unsigned ST_ACC_ERR = 3;
  localparam int unsigned ST_RSV_ERR = 4;
  localparam int unsigned ST_BUSY = 5;
  localparam int unsigned ST_BANK_LSB = 8;
  localparam int unsigned CT_ENABLE = 0;
  localparam logic CTRL_RESET = 1'b1;

endpackage

// ### rtl/dmb_ddr_mode_burst.sv
// ddr command decoder with mode registers, burst ordering and read latency
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
module dmb_ddr_mode_burst import dmb_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  output logic [12:0] beat_col,
  output logic [1:0] beat_bank,
  output logic beat_write,
  output logic pin_beat,
  output logic core_beat,
  output logic burst_busy,
  output logic dll_reset_pulse
);

  // ==========================================================
  // declarations
  // ==========================================================
  dmb_cmd_t pin_in, s1_ff, s2_ff, s3_ff, cmd_lvl_ff, cmd;
  logic [2:0] cks_ff, op;
  logic ck_lvl_ff, ck_agree, ck_rise, ck_edge, take;
  logic do_base, do_ext, dll_pat, norm_pat, rw_cmd, rw_ok;
  logic [12:0] mode_ff, emode_ff, start_col_ff, col_ff;
  logic mode_ok_ff, emode_ok_ff, dll_pend_ff, dll_pulse_ff, acc_err_ff, rsv_err_ff;
  logic [3:0] open_ff;
  logic ctrl_en_ff, wr_ff, ilv_ff, beat_now, last_beat, owr_ff;
  dmb_state_t state_ff, nxt_state;
  logic [1:0] bank_ff, obank_ff;
  logic [2:0] mask_ff, lat_ff, k_ff, nxt_mask, nxt_lat, low;
  logic pin_beat_ff, core_beat_ff, busy_ff, acc, wr_acc, mapped;
  logic [31:0] rd_mux, stat_w, prdata_ff;
  logic pready_ff, pslverr_ff;

  // ==========================================================
  // link pin synchroniser
  // ==========================================================
  assign pin_in = {cke, cs_n, ras_n, cas_n, we_n, ba, addr};

  // three stages for the command pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // three stages for the link clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cks_ff <= 3'h0;
    end else begin
      cks_ff <= {cks_ff[1:0], ck};
    end
  end

  // a change counts once stages two and three agree
  assign ck_agree = (cks_ff[1] == cks_ff[2]);
  assign ck_edge = ck_agree & (cks_ff[2] != ck_lvl_ff);
  assign ck_rise = ck_edge & cks_ff[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_lvl_ff <= 1'b0;
    end else if (ck_agree) begin
      ck_lvl_ff <= cks_ff[2];
    end
  end

  // settled command level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_lvl_ff <= '1;
    end else if (s2_ff == s3_ff) begin
      cmd_lvl_ff <= s3_ff;
    end
  end

  assign cmd = (s2_ff == s3_ff) ? s3_ff : cmd_lvl_ff;

  // ==========================================================
  // command decode
  // ==========================================================
  // deselect and nop fall through untaken
  assign take = ck_rise & ctrl_en_ff & cmd.cke & !cmd.cs_n;
  assign op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  assign do_base = take & (op == OP_MODE) & (cmd.ba == BA_BASE);
  assign do_ext = take & (op == OP_MODE) & (cmd.ba == BA_EXT);
  assign norm_pat = (cmd.addr[12:MR_OP_LSB] == MR_OP_NORMAL);
  assign dll_pat = (cmd.addr[12:MR_OP_LSB] == MR_OP_DLL);
  assign rw_cmd = take & ((op == OP_RD) | (op == OP_WR));
  assign rw_ok = rw_cmd & open_ff[cmd.ba];

  // ==========================================================
  // mode registers
  // ==========================================================
  // value held until the next matching mode set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 13'h0000;
      mode_ok_ff <= 1'b0;
    end else if (do_base) begin
      mode_ff <= cmd.addr;
      mode_ok_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      emode_ff <= 13'h0000;
      emode_ok_ff <= 1'b0;
    end else if (do_ext) begin
      emode_ff <= cmd.addr;
      emode_ok_ff <= 1'b1;
    end
  end

  // dll reset request and pending flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dll_pulse_ff <= 1'b0;
      dll_pend_ff <= 1'b0;
    end else begin
      dll_pulse_ff <= do_base & dll_pat;
      if (do_base & dll_pat) begin
        dll_pend_ff <= 1'b1;
      end else if (do_base & norm_pat) begin
        dll_pend_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // bank state and error flags
  // ==========================================================
  // open rows per bank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_ff <= 4'h0;
    end else if (take & (op == OP_ACT)) begin
      open_ff[cmd.ba] <= 1'b1;
    end else if (take & (op == OP_PRE)) begin
      if (cmd.addr[AP_BIT]) begin
        open_ff <= 4'h0;
      end else begin
        open_ff[cmd.ba] <= 1'b0;
      end
    end else if (rw_ok & cmd.addr[AP_BIT]) begin
      open_ff[cmd.ba] <= 1'b0;
    end
  end

  // sticky errors, write one clears, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_err_ff <= 1'b0;
    end else if ((rw_cmd & !rw_ok) | (take & (op == OP_REF) & (open_ff != 4'h0))) begin
      acc_err_ff <= 1'b1;
    end else if (wr_acc & (paddr == REG_STAT) & pwdata[ST_ACC_ERR]) begin
      acc_err_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsv_err_ff <= 1'b0;
    end else if (do_base & !norm_pat & !dll_pat) begin
      rsv_err_ff <= 1'b1;
    end else if (wr_acc & (paddr == REG_STAT) & pwdata[ST_RSV_ERR]) begin
      rsv_err_ff <= 1'b0;
    end
  end

  // ==========================================================
  // burst setup
  // ==========================================================
  // burst length and latency decode
  always_comb begin
    case (mode_ff[MR_BL_LSB +: 3])
      BL_2: nxt_mask = MASK_2;
      BL_4: nxt_mask = MASK_4;
      BL_8: nxt_mask = MASK_8;
      default: nxt_mask = MASK_8;
    endcase
    if (op == OP_WR) begin
      nxt_lat = LAT_WR;
    end else begin
      case (mode_ff[MR_CL_LSB +: 3])
        CL_2: nxt_lat = LAT_CL2;
        CL_25: nxt_lat = LAT_CL25;
        CL_3: nxt_lat = LAT_CL3;
        default: nxt_lat = LAT_CL3;
      endcase
    end
  end

  // latch burst parameters, same length for reads and writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_col_ff <= 13'h0000;
      bank_ff <= 2'h0;
      wr_ff <= 1'b0;
      ilv_ff <= 1'b0;
      mask_ff <= MASK_2;
    end else if (rw_ok) begin
      start_col_ff <= cmd.addr;
      bank_ff <= cmd.ba;
      wr_ff <= (op == OP_WR);
      ilv_ff <= mode_ff[MR_BT_BIT];
      mask_ff <= nxt_mask;
    end
  end

  // ==========================================================
  // burst sequencer
  // ==========================================================
  assign beat_now = ck_edge & (((state_ff == ST_WAIT) & (lat_ff == 3'h1))
                    | (state_ff == ST_XFER));
  assign last_beat = ((k_ff & mask_ff) == mask_ff);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (rw_ok) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (ck_edge & (lat_ff == 3'h1)) begin
          nxt_state = ST_XFER;
        end
      end
      ST_XFER: begin
        if (beat_now & last_beat) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // a new access or a read stop overrides the running burst
    if (rw_ok) begin
      nxt_state = ST_WAIT;
    end else if (take & (op == OP_STOP) & !wr_ff) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // latency counted in link edges from the command edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_ff <= 3'h0;
    end else if (rw_ok) begin
      lat_ff <= nxt_lat;
    end else if (ck_edge & (state_ff == ST_WAIT)) begin
      lat_ff <= lat_ff - 3'h1;
    end
  end

  // beat index inside the burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k_ff <= 3'h0;
    end else if (rw_ok) begin
      k_ff <= 3'h0;
    end else if (beat_now) begin
      k_ff <= k_ff + 3'h1;
    end
  end

  // low column bits of this beat
  always_comb begin
    if (ilv_ff) begin
      low = start_col_ff[2:0] ^ k_ff;
    end else begin
      low = start_col_ff[2:0] + k_ff;
    end
  end

  // ==========================================================
  // beat outputs
  // ==========================================================
  // one pin word per link edge, a core word on every pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_ff <= 13'h0000;
      obank_ff <= 2'h0;
      owr_ff <= 1'b0;
      pin_beat_ff <= 1'b0;
      core_beat_ff <= 1'b0;
    end else begin
      pin_beat_ff <= beat_now;
      core_beat_ff <= beat_now & !k_ff[0];
      if (beat_now) begin
        // upper bits fix the aligned block, low bits wrap in it
        col_ff <= {start_col_ff[12:3],
                   (start_col_ff[2:0] & ~mask_ff) | (low & mask_ff)};
        obank_ff <= bank_ff;
        owr_ff <= wr_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
    end
  end

  // ==========================================================
  // apb slave
  // ==========================================================
  assign acc = psel & penable & !pready_ff;
  assign wr_acc = acc & pwrite;
  assign mapped = (paddr == REG_MODE) | (paddr == REG_EMODE)
                  | (paddr == REG_STAT) | (paddr == REG_CTRL);

  always_comb begin
    stat_w = 32'h0000_0000;
    stat_w[ST_MODE_OK] = mode_ok_ff;
    stat_w[ST_EMODE_OK] = emode_ok_ff;
    stat_w[ST_DLL_PEND] = dll_pend_ff;
    stat_w[ST_ACC_ERR] = acc_err_ff;
    stat_w[ST_RSV_ERR] = rsv_err_ff;
    stat_w[ST_BUSY] = busy_ff;
    stat_w[ST_BANK_LSB +: 4] = open_ff;
    case (paddr)
      REG_MODE: rd_mux = {19'h0, mode_ff};
      REG_EMODE: rd_mux = {19'h0, emode_ff};
      REG_STAT: rd_mux = stat_w;
      REG_CTRL: rd_mux = {31'h0, ctrl_en_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= acc;
      pslverr_ff <= acc & !mapped;
      if (acc & !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  // command acceptance enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_ff <= CTRL_RESET;
    end else if (wr_acc & (paddr == REG_CTRL)) begin
      ctrl_en_ff <= pwdata[CT_ENABLE];
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign beat_col = col_ff;
  assign beat_bank = obank_ff;
  assign beat_write = owr_ff;
  assign pin_beat = pin_beat_ff;
  assign core_beat = core_beat_ff;
  assign burst_busy = busy_ff;
  assign dll_reset_pulse = dll_pulse_ff;

endmodule // dmb_ddr_mode_burst

// ### tb/dmb_mode_burst_checker.sv
// assertion checker for the ddr mode and burst block ports
`timescale 1ns/10ps
module dmb_mode_burst_checker import dmb_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  input wire logic [12:0] beat_col,
  input wire logic [1:0] beat_bank,
  input wire logic pin_beat,
  input wire logic core_beat,
  input wire logic burst_busy,
  input wire logic dll_reset_pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================
  // register bus answers
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready without an access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside the pready cycle");

  // ==========================================
  // burst beats
  a_pin_beat_pulse: assert property (pin_beat |=> !pin_beat)
    else $error("pin beat wider than one cycle");
  a_core_on_pin: assert property (core_beat |-> pin_beat)
    else $error("core beat without a pin beat");
  a_odd_beat_pair: assert property (pin_beat && !core_beat |->
      beat_col[0] != $past(beat_col[0]) && beat_col[12:3] == $past(beat_col[12:3])
      && beat_bank == $past(beat_bank))
    else $error("second word of a pair left its column block");
  a_beat_in_busy: assert property (pin_beat |-> $past(burst_busy))
    else $error("pin beat outside a burst");
  a_busy_to_beat: assert property ($rose(burst_busy) |-> ##[1:64] pin_beat)
    else $error("burst started but no beat came");

  // ==========================================
  // dll reset
  a_dll_once: assert property (dll_reset_pulse |=> !dll_reset_pulse)
    else $error("dll reset pulse too long");
  a_dll_cause: assert property (dll_reset_pulse |-> $past(addr[8]) &&
      $past(ba) == BA_BASE && !$past(cs_n) && !$past(we_n))
    else $error("dll reset without a base mode set with bit 8");
endmodule // dmb_mode_burst_checker

// ### tb/dmb_ctrl_model.sv
// memory controller model that drives the ddr command pins
`timescale 1ns/10ps
module dmb_ctrl_model import dmb_pkg::*; #(
  parameter int POWERUP_CK = 3125,
  parameter int PRE_WAIT_CK = 2,
  parameter int MODE_WAIT_CK = 2
) (
  output logic ck,
  output dmb_cmd_t cmd
);
  // ==========================================
  // free running link clock, idle bus with cke low
  initial begin
    cmd = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
    ck = 1'b0;
    forever #32 ck = ~ck; // never stopped
  end

  // one command around one rise; released lines toggle
  task automatic send(input logic [2:0] op, input logic [1:0] b, input logic [12:0] a);
    @(negedge ck);
    cmd <= '{1'b1, 1'b0, op[2], op[1], op[0], b, a};
    @(negedge ck);
    cmd <= '{1'b1, 1'b1, ~op[2], ~op[1], ~op[0], ~b, ~a};
  endtask

  // deselect for n link clocks
  task automatic idle(input int n);
    repeat (n) @(negedge ck);
  endtask

  // ==========================================
  // power-up sequence
  task automatic init(input logic [12:0] ext, input logic [12:0] mode);
    @(negedge ck);
    cmd.cke <= 1'b1; // clocks stable, deselect only
    idle(POWERUP_CK);
    send(OP_PRE, 2'h0, 13'h0400); // all banks
    idle(PRE_WAIT_CK); // wait counted in deselect clocks
    send(OP_MODE, BA_EXT, ext); // both registers programmed
    send(OP_MODE, BA_BASE, mode | 13'h0100); // dll reset
    idle(MODE_WAIT_CK);
    send(OP_PRE, 2'h0, 13'h0400); // banks idle before refresh
    send(OP_REF, 2'h0, 13'h0000); // refreshes kept in place
    send(OP_REF, 2'h0, 13'h0000);
    send(OP_MODE, BA_BASE, mode); // normal mode after dll reset
    idle(200);
  endtask
endmodule // dmb_ctrl_model

// ### tb/tb.sv
// testbench for the ddr mode and burst block
`timescale 1ns/10ps
module tb import dmb_pkg::*; ();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ck, err, wr_seen;
  logic beat_write, pin_beat, core_beat, burst_busy, dll_reset_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] beat_col;
  logic [1:0] beat_bank;
  dmb_cmd_t cmd;
  logic [12:0] cols[$];
  time t_first;
  int err_count = 0;
  int check_count = 0;
  int dll_count = 0;

  dmb_ddr_mode_burst dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .ck, .cke(cmd.cke), .cs_n(cmd.cs_n), .ras_n(cmd.ras_n),
    .cas_n(cmd.cas_n), .we_n(cmd.we_n), .ba(cmd.ba), .addr(cmd.addr), .beat_col, .beat_bank,
    .beat_write, .pin_beat, .core_beat, .burst_busy, .dll_reset_pulse);
  dmb_ctrl_model #(.POWERUP_CK(4)) ctl (.ck, .cmd);

  // ==========================================
  // clock and beat monitor
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (pin_beat === 1'b1) begin
      if (cols.size() == 0) t_first = $time;
      cols.push_back(beat_col);
      wr_seen = wr_seen | beat_write;
    end
    if (dll_reset_pulse === 1'b1) dll_count++;
  end

  // ==========================================
  // compare, verdict, bus access
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one burst: mode set, row open, access, order and latency compare
  task automatic burst(input logic wr, input logic [2:0] blc, input logic bt,
                       input logic [12:0] s);
    logic [12:0] e;
    logic [2:0] cl;
    int bl, lat, n;
    time tc;
    bl = 1 << blc;
    cl = (blc == BL_2) ? CL_2 : (blc == BL_4) ? CL_25 : CL_3;
    lat = wr ? 2 : (cl == CL_25) ? 3 : 2 * cl - 2;
    ctl.send(OP_MODE, BA_BASE, {6'h00, cl, bt, blc}); // banks idle, spare bits zero
    ctl.idle(2);
    ctl.send(OP_ACT, 2'h2, 13'h0055);
    cols.delete();
    wr_seen = 1'b0;
    ctl.send(wr ? OP_WR : OP_RD, 2'h2, s);
    tc = $time - 32;
    ctl.idle(8);
    check(32'(cols.size()), 32'(bl));
    check(32'(wr_seen), 32'(wr));
    check(32'(beat_bank), 32'h2);
    n = int'(t_first - tc);
    check(32'(n >= lat * 32 && n <= lat * 32 + 40), 32'h1);
    for (int k = 0; k < bl; k++) begin
      e = bt ? (s ^ 13'(k)) : ((s & ~13'(bl - 1)) | ((s + 13'(k)) & 13'(bl - 1)));
      check(32'(cols[k]), 32'(e));
    end
    ctl.send(OP_PRE, 2'h2, 13'h0000);
  endtask

  // ==========================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wr_seen} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, REG_MODE, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(err), 32'h1);
    ctl.init(13'h0002, 13'h0032);
    check(32'(dll_count), 32'h1);
    apb(1'b0, REG_EMODE, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, REG_MODE, 32'h1FFF);
    apb(1'b0, REG_MODE, 32'h0);
    check(rd, 32'h32);
    apb(1'b0, REG_STAT, 32'h0);
    check(rd & 32'h13, 32'h3);
    for (int b = 1; b <= 3; b++) begin
      for (int t = 0; t < 2; t++) begin
        burst(1'b0, 3'(b), t[0], 13'h01F0 | 13'(b * 2 + t + 1));
      end
    end
    burst(1'b1, BL_8, 1'b1, 13'h0125);
    cols.delete();
    ctl.send(OP_RD, 2'h1, 13'h0000);
    ctl.idle(8);
    check(32'(cols.size()), 32'h0);
    apb(1'b0, REG_STAT, 32'h0);
    check(rd & 32'h8, 32'h8);
    ctl.send(OP_MODE, BA_BASE, 13'h0832);
    ctl.idle(2);
    apb(1'b0, REG_STAT, 32'h0);
    check(rd & 32'h10, 32'h10);
    check(32'(dll_count), 32'h1);
    // sticky error flags clear on a one written back
    apb(1'b1, REG_STAT, 32'h18);
    apb(1'b0, REG_STAT, 32'h0);
    check(rd & 32'h18, 32'h0);
    // with command acceptance off a mode set must be ignored
    apb(1'b1, REG_CTRL, 32'h0);
    ctl.send(OP_MODE, BA_BASE, 13'h0022);
    ctl.idle(2);
    apb(1'b0, REG_MODE, 32'h0);
    check(rd, 32'h832);
    apb(1'b1, REG_CTRL, 32'h1);
    ctl.send(OP_MODE, BA_BASE, 13'h0022);
    ctl.idle(2);
    apb(1'b0, REG_MODE, 32'h0);
    check(rd, 32'h22);
    tally_and_finish();
  end
endmodule // tb

bind dmb_ddr_mode_burst dmb_mode_burst_checker chk (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .cs_n, .we_n, .ba, .addr, .beat_col, .beat_bank, .pin_beat, .core_beat, .burst_busy,
  .dll_reset_pulse);
